// ---- fspc_map.svh ----
// Purpose: offsets, field positions, codes and reset values of the
//          flash self-programming controller
// Assumes: AXI4-Lite byte addresses, one 32-bit word per register
// Notes:   8-bit registers sit in bits 7:0, upper bits read zero
`ifndef FSPC_MAP_SVH
`define FSPC_MAP_SVH

`define FSPC_OFS_CMD 6'h00
`define FSPC_OFS_STATUS 6'h04
`define FSPC_OFS_PROTECT 6'h08
`define FSPC_OFS_MODE 6'h0c
`define FSPC_OFS_PTR_HI 6'h10
`define FSPC_OFS_PTR_LO 6'h14
`define FSPC_OFS_CMP_HI 6'h18
`define FSPC_OFS_CMP_LO 6'h1c
`define FSPC_OFS_WDT 6'h20
`define FSPC_OFS_HALT 6'h24
`define FSPC_OFS_IRQ_STAT 6'h28
`define FSPC_OFS_IRQ_MASK 6'h2c

`define FSPC_BIT_SEQ_ERR 0
`define FSPC_BIT_VERIFY_ERR 1
`define FSPC_BIT_PROT_ERR 2

`define FSPC_IRQ_DONE 0
`define FSPC_IRQ_CMD_ERR 1
`define FSPC_IRQ_SEQ_ERR 2

`define FSPC_CMD_ERASE 8'h03
`define FSPC_CMD_BLANK 8'h04
`define FSPC_PROTECT_KEY 8'ha5
`define FSPC_WDT_KEY 8'hac
`define FSPC_MODE_SELF 8'h01

`define FSPC_RST_BYTE 8'h00
`define FSPC_RST_FLAGS 3'h0
`define FSPC_RESP_OKAY 2'h0
`define FSPC_RESP_SLVERR 2'h2

`endif

// ---- fspc_pkg.sv ----
// Purpose: types shared by the flash self-programming controller
// Assumes: constants live in fspc_map.svh
// Notes:   none
package fspc_pkg;

  typedef enum logic [1:0] {
    FSPC_IDLE  = 2'b00,
    FSPC_CHECK = 2'b01,
    FSPC_BUSY  = 2'b10,
    FSPC_DONE  = 2'b11
  } fspc_state_e;

  typedef struct packed {
    logic valid;
    logic erase;
    logic [7:0] block;
    logic [7:0] lo;
    logic [7:0] hi_cmp;
    logic [7:0] lo_cmp;
  } fspc_flash_req_s;

endpackage : fspc_pkg

// ---- fspc_ctrl.sv ----
// Purpose: flash self-programming control, AXI4-Lite register slave
// Assumes: flash macro answers a request with one fl_done pulse
// Notes:   cpu_halt_o stands in for the cpu halt hold-off
//
// Summary of operation
// R1: software zeroes command, then clears status
// R2: A5 key, then value, inverse, value
// R3: only the third mode write takes effect
// R4: failed sequence sets status bit 0
// R5: software retries sequence after an error
// R6: software restores clock and interrupts after
// R7: software runs from untouched flash area
// R8: command 03 means block erase
// R9: erase pointers: block, 00, block, 00
// R10: command 04 means block blank check
// R11: blank pointers: block, 00, block, ff
// R12: software clears status before each command
// R13: halt starts command, cpu resumes after
// R14: bit 1 verify error, bit 2 protect
// R15: status zero means normal termination
// R16: software writes ac to restart watchdog
// R17: entry uses 01, fe, 01 pattern
// R18: software masks interrupts, raises clock first
// R19: cpu held until result flags written
`include "fspc_map.svh"

module fspc_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output fspc_pkg::fspc_flash_req_s fl_req,
  input wire logic fl_done,
  input wire logic fl_fail,
  input wire logic block_protected,
  output logic cpu_halt_o,
  output logic self_prog_mode,
  output logic wdt_restart,
  output logic irq
);
  import fspc_pkg::*;

  function automatic logic fspc_hit(input logic [5:0] a);
    fspc_hit = (a[1:0] == 2'h0) && (a <= `FSPC_OFS_IRQ_MASK);
  endfunction : fspc_hit

  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff, wdata_ff;
  logic [5:0] awaddr_ff;
  logic [3:0] wstrb_ff;
  logic [7:0] cmd_ff, ptr_hi_ff, ptr_lo_ff, cmp_hi_ff, cmp_lo_ff;
  logic [2:0] status_ff, irq_stat_ff, irq_mask_ff;
  logic mode_ff, halt_ff, wdt_ff, irq_ff;
  logic [1:0] seq_step_ff;
  logic [7:0] seq_val_ff;
  fspc_state_e st_ff;
  fspc_flash_req_s req_ff;

  logic wr_fire, wr_ok;
  logic [7:0] wd;
  logic seq_apply, seq_fail, err_verify, err_prot, cmd_end;
  logic is_flash_cmd;

  assign wr_fire = !awready_ff && !wready_ff && !bvalid_ff;
  // byte lane 0 carries every register; other lanes are ignored
  assign wr_ok = wr_fire && fspc_hit(awaddr_ff) && wstrb_ff[0];
  assign wd = wdata_ff[7:0];
  assign is_flash_cmd = (cmd_ff == `FSPC_CMD_ERASE) ||
                        (cmd_ff == `FSPC_CMD_BLANK);

  // write channels, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      awaddr_ff <= 6'h00;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        awready_ff <= 1'b0;
        awaddr_ff <= s_axi_awaddr;
      end else if (wr_fire) begin
        awready_ff <= 1'b1;
      end
      if (s_axi_wvalid && wready_ff) begin
        wready_ff <= 1'b0;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (wr_fire) begin
        wready_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `FSPC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= fspc_hit(awaddr_ff) ? `FSPC_RESP_OKAY : `FSPC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // read channel, answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= `FSPC_RESP_OKAY;
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rresp_ff <= fspc_hit(s_axi_araddr) ? `FSPC_RESP_OKAY
                                         : `FSPC_RESP_SLVERR;
      case (s_axi_araddr)
        `FSPC_OFS_CMD: rdata_ff <= {24'h0, cmd_ff};
        `FSPC_OFS_STATUS: rdata_ff <= {29'h0, status_ff}; // see R15
        `FSPC_OFS_MODE: rdata_ff <= {31'h0, mode_ff};
        `FSPC_OFS_PTR_HI: rdata_ff <= {24'h0, ptr_hi_ff};
        `FSPC_OFS_PTR_LO: rdata_ff <= {24'h0, ptr_lo_ff};
        `FSPC_OFS_CMP_HI: rdata_ff <= {24'h0, cmp_hi_ff};
        `FSPC_OFS_CMP_LO: rdata_ff <= {24'h0, cmp_lo_ff};
        `FSPC_OFS_HALT: rdata_ff <= {31'h0, halt_ff};
        `FSPC_OFS_IRQ_STAT: rdata_ff <= {29'h0, irq_stat_ff};
        `FSPC_OFS_IRQ_MASK: rdata_ff <= {29'h0, irq_mask_ff};
        default: rdata_ff <= 32'h0;
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  // command, pointer and interrupt mask registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_ff <= `FSPC_RST_BYTE;
      ptr_hi_ff <= `FSPC_RST_BYTE;
      ptr_lo_ff <= `FSPC_RST_BYTE;
      cmp_hi_ff <= `FSPC_RST_BYTE;
      cmp_lo_ff <= `FSPC_RST_BYTE;
      irq_mask_ff <= `FSPC_RST_FLAGS;
    end else if (wr_ok) begin
      case (awaddr_ff)
        `FSPC_OFS_CMD: cmd_ff <= wd;
        `FSPC_OFS_PTR_HI: ptr_hi_ff <= wd;
        `FSPC_OFS_PTR_LO: ptr_lo_ff <= wd;
        `FSPC_OFS_CMP_HI: cmp_hi_ff <= wd;
        `FSPC_OFS_CMP_LO: cmp_lo_ff <= wd;
        `FSPC_OFS_IRQ_MASK: irq_mask_ff <= wd[2:0];
        default: ;
      endcase
    end
  end

  // protected mode sequence: key, value, inverse, value
  always_comb begin
    seq_apply = 1'b0;
    seq_fail = 1'b0;
    if (wr_ok && awaddr_ff == `FSPC_OFS_MODE) begin
      case (seq_step_ff)
        2'h1: seq_fail = 1'b0;
        2'h2: seq_fail = (wd != ~seq_val_ff); // see R2
        2'h3: begin
          seq_apply = (wd == seq_val_ff); // see R3
          seq_fail = (wd != seq_val_ff);
        end
        default: seq_fail = 1'b1;
      endcase
    end else if (wr_ok && seq_step_ff != 2'h0 &&
                 awaddr_ff != `FSPC_OFS_PROTECT) begin
      // any foreign write breaks the sequence
      seq_fail = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_step_ff <= 2'h0;
      seq_val_ff <= `FSPC_RST_BYTE;
    end else if (wr_ok) begin
      if (awaddr_ff == `FSPC_OFS_PROTECT) begin
        seq_step_ff <= (wd == `FSPC_PROTECT_KEY) ? 2'h1 : 2'h0; // see R2
      end else if (seq_fail || seq_apply) begin
        seq_step_ff <= 2'h0;
      end else if (awaddr_ff == `FSPC_OFS_MODE) begin
        if (seq_step_ff == 2'h1) begin
          seq_val_ff <= wd;
        end
        seq_step_ff <= seq_step_ff + 2'h1;
      end
    end
  end

  // first two mode writes only arm the check
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_ff <= 1'b0;
    end else if (seq_apply) begin
      mode_ff <= (seq_val_ff == `FSPC_MODE_SELF); // see R3, R17
    end
  end

  // command engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= FSPC_IDLE;
      halt_ff <= 1'b0;
      req_ff <= '0;
    end else begin
      req_ff.valid <= 1'b0;
      case (st_ff)
        FSPC_IDLE: begin
          if (wr_ok && awaddr_ff == `FSPC_OFS_HALT && wd[0]) begin
            halt_ff <= 1'b1; // see R13
            st_ff <= FSPC_CHECK;
          end
        end
        FSPC_CHECK: begin
          if (is_flash_cmd && mode_ff && !block_protected) begin
            req_ff.valid <= 1'b1;
            req_ff.erase <= (cmd_ff == `FSPC_CMD_ERASE); // see R8, R10
            req_ff.block <= ptr_hi_ff;
            req_ff.lo <= ptr_lo_ff;
            req_ff.hi_cmp <= cmp_hi_ff;
            req_ff.lo_cmp <= cmp_lo_ff;
            st_ff <= FSPC_BUSY;
          end else begin
            st_ff <= FSPC_DONE;
          end
        end
        FSPC_BUSY: begin
          if (fl_done) begin
            st_ff <= FSPC_DONE;
          end
        end
        FSPC_DONE: begin
          // flags were written last cycle, so the cpu sees them
          halt_ff <= 1'b0; // see R19
          st_ff <= FSPC_IDLE;
        end
        default: st_ff <= FSPC_IDLE;
      endcase
    end
  end

  // protection error: no self mode or protected block
  assign err_prot = (st_ff == FSPC_CHECK) && is_flash_cmd &&
                    (!mode_ff || block_protected);
  assign err_verify = (st_ff == FSPC_BUSY) && fl_done && fl_fail;
  assign cmd_end = (st_ff == FSPC_DONE);

  // set wins over a same-cycle software write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_ff <= `FSPC_RST_FLAGS;
    end else begin
      status_ff <= ((wr_ok && awaddr_ff == `FSPC_OFS_STATUS) ?
                    wd[2:0] : status_ff) |
                   {err_prot, err_verify, seq_fail}; // see R4, R14
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_ff <= `FSPC_RST_FLAGS;
    end else begin
      irq_stat_ff <= (irq_stat_ff &
                      ~((wr_ok && awaddr_ff == `FSPC_OFS_IRQ_STAT) ?
                        wd[2:0] : 3'h0)) |
                     {seq_fail, err_prot | err_verify, cmd_end};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_ff <= 1'b0;
      wdt_ff <= 1'b0;
    end else begin
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
      wdt_ff <= wr_ok && awaddr_ff == `FSPC_OFS_WDT &&
                wd == `FSPC_WDT_KEY;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign fl_req = req_ff;
  assign cpu_halt_o = halt_ff;
  assign self_prog_mode = mode_ff;
  assign wdt_restart = wdt_ff;
  assign irq = irq_ff;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_mode_third_only: assert property ( // see R3
    $changed(mode_ff) |-> $past(seq_apply))
    else $error("mode changed outside a full sequence");
  a_seq_err_flag: assert property ( // see R4
    seq_fail |=> status_ff[`FSPC_BIT_SEQ_ERR])
    else $error("sequence error not flagged");
  a_erase_decode: assert property ( // see R8
    st_ff == FSPC_CHECK && cmd_ff == `FSPC_CMD_ERASE && mode_ff &&
    !block_protected |=> fl_req.valid && fl_req.erase)
    else $error("erase command not issued");
  a_blank_decode: assert property ( // see R10
    st_ff == FSPC_CHECK && cmd_ff == `FSPC_CMD_BLANK && mode_ff &&
    !block_protected |=> fl_req.valid && !fl_req.erase)
    else $error("blank check not issued");
  a_halt_hold: assert property ( // see R19
    st_ff == FSPC_BUSY |-> cpu_halt_o)
    else $error("cpu released during flash operation");
  a_verify_err: assert property ( // see R14
    err_verify |=> status_ff[`FSPC_BIT_VERIFY_ERR] ##1 !cpu_halt_o)
    else $error("verify error or release wrong");
  a_protect_err: assert property ( // see R14
    err_prot |=> status_ff[`FSPC_BIT_PROT_ERR] && st_ff == FSPC_DONE)
    else $error("protect error not flagged");
  a_halt_resume: assert property ( // see R13
    $rose(cpu_halt_o) && !is_flash_cmd |-> ##2 !cpu_halt_o)
    else $error("halt without command not released");

  c_erase_done: cover property (
    fl_req.valid && fl_req.erase ##[1:50] cmd_end);
  c_blank_done: cover property (
    fl_req.valid && !fl_req.erase ##[1:50] cmd_end);
  c_mode_switch: cover property (seq_apply);
  c_seq_error: cover property (seq_fail);

endmodule : fspc_ctrl

// ---- fspc_flash_model.sv ----
// Purpose: behavioural flash array for block erase and blank check
// Assumes: one request at a time, answered after dly+1 idle cycles
// Notes:   fl_fail toggles outside done, so a stale level never passes
module fspc_flash_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire fspc_pkg::fspc_flash_req_s fl_req,
  input wire logic [7:0] dly,
  input wire logic fail,
  output logic fl_done,
  output logic fl_fail
);
  timeunit 1ns;
  timeprecision 1ps;
  import fspc_pkg::*;
  logic [7:0] cnt_ff;
  logic busy_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_ff <= 1'b0;
      cnt_ff <= 8'h00;
      fl_done <= 1'b0;
      fl_fail <= 1'b0;
    end else begin
      fl_done <= 1'b0;
      fl_fail <= ~fl_fail;
      if (fl_req.valid) begin
        busy_ff <= 1'b1;
        cnt_ff <= dly;
      end else if (busy_ff && cnt_ff == 8'h00) begin
        busy_ff <= 1'b0;
        fl_done <= 1'b1;
        fl_fail <= fail;
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff - 8'h01;
      end
    end
  end
endmodule : fspc_flash_model

// ---- fspc_ctrl_bench.sv ----
// Purpose: self-checking bench of the flash self-programming control
// Assumes: AXI4-Lite master tasks, flash model on the request port
// Notes:   reads, responses and flash requests are checked from queues
`include "fspc_map.svh"
module fspc_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import fspc_pkg::*;
  logic aclk, aresetn, awv, wv, bry, arv, rry, prot, fail, fd, ff;
  logic awr, wrd, bv, arr, rv, halt, spm, wdt, irq;
  logic [5:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [3:0] ws;
  logic [1:0] br, rr;
  logic [7:0] dly, b;
  fspc_flash_req_s req;
  logic [33:0] q_r[$];
  logic [1:0] q_b[$];
  logic [33:0] q_f[$];
  int num_errors = 0;
  int n_checks = 0;
  int wdt_cnt = 0;
  int h;
  fspc_ctrl i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .fl_req(req), .fl_done(fd), .fl_fail(ff),
    .block_protected(prot), .cpu_halt_o(halt), .self_prog_mode(spm),
    .wdt_restart(wdt), .irq(irq));
  fspc_flash_model i_flash (.aclk(aclk), .aresetn(aresetn), .fl_req(req),
    .dly(dly), .fail(fail), .fl_done(fd), .fl_fail(ff));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic hang();
    num_errors++;
    test_done();
  endtask : hang
  task automatic chk(input string nm, input logic [33:0] e, g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // results are paired with the oldest note as they appear
  always @(posedge aclk) begin
    if (rv && rry) chk("read", q_r.size() ? q_r.pop_front() : 'x, {rr, rdat});
    if (bv && bry) chk("bresp", q_b.size() ? q_b.pop_front() : 'x, br);
    if (req.valid) chk("flash req", q_f.size() ? q_f.pop_front() : 'x, req);
    if (fd) chk("halt at done", 1, halt);
    if (wdt) wdt_cnt++;
  end
  task automatic wr(input logic [5:0] a, input logic [7:0] d,
                    input logic [1:0] e = 2'h0);
    int n;
    @(posedge aclk);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    q_b.push_back(e);
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrd) wv <= 1'b0;
      if (bv) break;
    end
    bry <= 1'b0;
    if (n == 40) hang();
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] d,
                    input logic [1:0] e = 2'h0);
    int n;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    q_r.push_back({e, 24'h0, d});
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arv && arr) arv <= 1'b0;
      if (rv) break;
    end
    rry <= 1'b0;
    if (n == 40) hang();
  endtask : rd
  task automatic seq(input logic [7:0] v, w, x);
    wr(`FSPC_OFS_PROTECT, `FSPC_PROTECT_KEY);
    wr(`FSPC_OFS_MODE, v);
    wr(`FSPC_OFS_MODE, w);
    wr(`FSPC_OFS_MODE, x);
  endtask : seq
  // software side of a command: pointers, status clear, watchdog, halt
  task automatic cmd(input logic [7:0] c, lc, st, input bit go,
                     output int n);
    wr(`FSPC_OFS_CMD, c);
    wr(`FSPC_OFS_PTR_HI, b);
    wr(`FSPC_OFS_PTR_LO, 8'h00);
    wr(`FSPC_OFS_CMP_HI, b);
    wr(`FSPC_OFS_CMP_LO, lc);
    wr(`FSPC_OFS_STATUS, 8'h00);
    wr(`FSPC_OFS_WDT, `FSPC_WDT_KEY);
    // valid is the top bit of the request word
    if (go) q_f.push_back({1'b1, c == `FSPC_CMD_ERASE, b, 8'h00, b, lc});
    wr(`FSPC_OFS_HALT, 8'h01);
    for (n = 0; n < 200 && !halt; n++) @(posedge aclk);
    if (n == 200) hang();
    for (n = 0; n < 200 && halt; n++) @(posedge aclk);
    if (n == 200) hang();
    rd(`FSPC_OFS_STATUS, st);
  endtask : cmd
  initial begin
    #400000;
    hang();
  end
  initial begin
    void'($urandom(32'hb89e));
    {aresetn, awv, wv, bry, arv, rry, prot, fail} = 8'h00;
    {awa, ara, wd, ws, dly, b} = '0;
    ws = 4'h1;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`FSPC_OFS_MODE, 8'h00);
    rd(6'h30, 8'h00, `FSPC_RESP_SLVERR);
    wr(6'h31, 8'h01, `FSPC_RESP_SLVERR);
    ws <= 4'h0;
    wr(`FSPC_OFS_PTR_HI, 8'h5a);
    ws <= 4'h1;
    rd(`FSPC_OFS_PTR_HI, 8'h00);
    wr(`FSPC_OFS_IRQ_MASK, 8'h00);
    rd(`FSPC_OFS_IRQ_MASK, 8'h00);
    $display("test reset and map done");
    wr(`FSPC_OFS_PROTECT, `FSPC_PROTECT_KEY);
    wr(`FSPC_OFS_MODE, 8'h01);
    rd(`FSPC_OFS_MODE, 8'h00);
    wr(`FSPC_OFS_MODE, 8'hfe);
    rd(`FSPC_OFS_MODE, 8'h00);
    wr(`FSPC_OFS_MODE, 8'h01);
    rd(`FSPC_OFS_MODE, 8'h01);
    chk("self mode", 1, spm);
    wr(`FSPC_OFS_IRQ_MASK, 8'h04);
    seq(8'h00, 8'h00, 8'h00);
    rd(`FSPC_OFS_STATUS, 8'h01);
    rd(`FSPC_OFS_MODE, 8'h01);
    chk("irq raised", 1, irq);
    wr(`FSPC_OFS_IRQ_STAT, 8'h04);
    rd(`FSPC_OFS_IRQ_STAT, 8'h00);
    chk("irq cleared", 0, irq);
    $display("test protected entry done");
    // erase, blank fail, erase, blank on a protected block
    for (int i = 0; i < 4; i++) begin
      b <= 8'($urandom_range(0, 255));
      dly <= 8'($urandom_range(0, 9));
      fail <= (i == 1);
      prot <= (i == 3);
      cmd(i[0] ? `FSPC_CMD_BLANK : `FSPC_CMD_ERASE, i[0] ? 8'hff : 8'h00,
          i == 1 ? 8'h02 : i == 3 ? 8'h04 : 8'h00, i != 3, h);
      chk("watchdog pulses", i + 1, wdt_cnt);
    end
    prot <= 1'b0;
    cmd(8'h05, 8'h00, 8'h00, 1'b0, h);
    chk("halt cycles", 2, h);
    $display("test commands done");
    wr(`FSPC_OFS_CMD, 8'h00);
    wr(`FSPC_OFS_STATUS, 8'h00);
    seq(8'h00, 8'hff, 8'h01);
    rd(`FSPC_OFS_STATUS, 8'h01);
    wr(`FSPC_OFS_STATUS, 8'h00);
    seq(8'h00, 8'hff, 8'h00);
    rd(`FSPC_OFS_STATUS, 8'h00);
    rd(`FSPC_OFS_MODE, 8'h00);
    chk("normal mode", 0, spm);
    wr(`FSPC_OFS_IRQ_MASK, 8'h04);
    rd(`FSPC_OFS_IRQ_MASK, 8'h04);
    chk("irq after retry", 1, irq);
    $display("test return to normal done");
    cmd(`FSPC_CMD_ERASE, 8'h00, 8'h04, 1'b0, h);
    $display("test command in normal mode done");
    repeat (4) @(posedge aclk);
    // a note never matched means a result never appeared
    chk("notes left", 0, q_r.size() + q_b.size() + q_f.size());
    test_done();
  end
endmodule : fspc_ctrl_bench
